// file: shared/pmsob_pkg.sv
// constants and types shared by the soft-off and status-byte block
package pmsob_pkg;

    // ************************************************
    // command codes
    // ************************************************
    localparam logic [7:0] CMD_WAIT = 8'h64;
    localparam logic [7:0] CMD_RAMP = 8'h65;
    localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
    localparam logic [7:0] CMD_STATUS_WORD = 8'h79;

    // ************************************************
    // field layout and reset values
    // ************************************************
    localparam int EXP_MSB = 15;
    localparam int EXP_LSB = 11;
    localparam int MAN_MSB = 10;
    localparam logic [4:0] WAIT_EXP_RST = 5'h1f;
    localparam logic [4:0] RAMP_EXP_RST = 5'h1e;
    localparam logic [7:0] SB_RESET = 8'h00;
    localparam logic [7:0] SB_CLEAR_BUSY = 8'h80;
    localparam logic [15:0] SW_CLEAR_BUSY = 16'h0080;
    localparam logic [15:0] SW_CLEAR_BOTH = 16'h0180;
    localparam int SB_BUSY = 7;
    localparam int SB_OFF = 6;
    localparam int SB_OTHER = 0;

    // ************************************************
    // ranges in quarter milliseconds
    // ************************************************
    localparam int WAIT_MAX_Q = 510;
    localparam int WAIT_STEP_Q = 2;
    localparam int RAMP_MAX_Q = 127;
    localparam int RAMP_STEP_Q = 1;
    localparam logic [6:0] RAMP_MIN_Q = 7'h02;

    // ************************************************
    // timing
    // ************************************************
    localparam int CLK_HZ = 50_000_000;
    localparam int QUARTER_MS_US = 250;
    localparam int QMS_CYCLES = CLK_HZ / 1_000_000 * QUARTER_MS_US;
    localparam int LATENCY_MAX_US = 50;
    localparam int LATENCY_MAX_CYCLES = CLK_HZ / 1_000_000 * LATENCY_MAX_US;
    localparam int DIV_STEPS = 13;
    localparam int TICK_W = 14;

    // ************************************************
    // state
    // ************************************************
    typedef enum logic [2:0] {
        SEQ_OFF = 3'b000,
        SEQ_RUN = 3'b001,
        SEQ_DIV = 3'b010,
        SEQ_WAIT = 3'b011,
        SEQ_RAMP = 3'b100
    } pmsob_seq_e;

    typedef struct packed {
        pmsob_seq_e seq;
        logic loaded;
        logic [7:0] wait_half;
        logic [6:0] ramp_q;
        logic busy;
        logic unknown;
        logic alert;
        logic [TICK_W-1:0] tick;
        logic [8:0] qcnt;
        logic [11:0] ref_lvl;
        logic [7:0] rem;
        logic [12:0] quo;
        logic [3:0] dcnt;
        logic [15:0] rd_data;
        logic rd_valid;
        logic cmd_hit;
        logic inval;
        logic [7:0] sb;
    } pmsob_state_s;

    localparam pmsob_state_s ST_RESET = '0;

endpackage

// file: shared/pmsob_dec_if.sv
// carrier between the command logic and a time-value decoder
`timescale 1ns/1ps
`default_nettype none
interface pmsob_dec_if;
    logic [15:0] word;
    logic [8:0] quarters;
    logic ok;
    modport dec (input word, output quarters, output ok);
    modport user (output word, input quarters, input ok);
endinterface
`default_nettype wire

// file: hw/pmsob_lin11_decode.sv
// decoder of an 11-bit-mantissa linear time value into quarter milliseconds
`timescale 1ns/1ps
`default_nettype none
module pmsob_lin11_decode
    import pmsob_pkg::*;
#(
    parameter int MAX_Q = 510,
    parameter int STEP_Q = 1
) (
    pmsob_dec_if.dec dif
);

    // ************************************************
    // value = mantissa * 2^(exponent + 2), in quarter ms
    // ************************************************
    always_comb begin
        logic signed [4:0] e;
        logic signed [6:0] sh;
        logic [31:0] mag;
        logic [31:0] full;
        logic exact;
        e = dif.word[EXP_MSB:EXP_LSB];
        sh = 7'(e) + 7'sd2;
        mag = {22'h0, dif.word[MAN_MSB-1:0]};
        full = '0;
        exact = 1'b1;
        if (sh >= 0) begin
            full = mag << sh[4:0];
        end else begin
            full = mag >> 5'(-sh);
            exact = ((full << 5'(-sh)) == mag);
        end
        dif.ok = !dif.word[MAN_MSB] && exact && (full <= 32'(MAX_Q))
            && ((full % 32'(STEP_Q)) == 32'h0);
        dif.quarters = full[8:0];
    end

endmodule
`default_nettype wire

// file: hw/pmsob_top.sv
// turn-off wait, soft-off ramp and fault summary byte command logic
`timescale 1ns/1ps
`default_nettype none
module pmsob_top
    import pmsob_pkg::*;
#(
    parameter int QMS_CYCLES_P = QMS_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_wdata,
    output logic [15:0] rd_data,
    output logic rd_valid,
    output logic cmd_hit,
    output logic invalid_data,
    input wire logic [10:0] nvm_wait_mantissa,
    input wire logic [10:0] nvm_ramp_mantissa,
    input wire logic run_req,
    input wire logic [11:0] output_setpoint,
    input wire logic output_overvoltage_flag,
    input wire logic output_overcurrent_flag,
    input wire logic input_undervoltage_flag,
    input wire logic temperature_flag,
    input wire logic comm_memory_logic_flag,
    input wire logic other_fault_flag,
    input wire logic turn_on_timeout,
    input wire logic busy_event,
    input wire logic alert_mask,
    input wire logic alert_clear,
    output logic energy_on,
    output logic [11:0] ref_level,
    output logic [7:0] fault_summary_byte,
    output logic alert_o,
    output logic alert_oe
);

    pmsob_state_s st_r;
    pmsob_state_s st_nxt;
    pmsob_dec_if wait_if ();
    pmsob_dec_if ramp_if ();
    logic [6:0] ramp_n;
    logic tick_end;
    logic [7:0] div_t;
    logic div_ge;

    // ************************************************
    // time-value decoders
    // ************************************************
    pmsob_lin11_decode #(.MAX_Q(WAIT_MAX_Q), .STEP_Q(WAIT_STEP_Q)) u_wait_dec (.dif(wait_if));
    pmsob_lin11_decode #(.MAX_Q(RAMP_MAX_Q), .STEP_Q(RAMP_STEP_Q)) u_ramp_dec (.dif(ramp_if));

    assign wait_if.word = cmd_wdata;
    assign ramp_if.word = cmd_wdata;
    assign ramp_n = (st_r.ramp_q < RAMP_MIN_Q) ? RAMP_MIN_Q : st_r.ramp_q;
    assign tick_end = (st_r.tick == TICK_W'(QMS_CYCLES_P - 1));
    assign div_t = {st_r.rem[6:0], st_r.quo[12]};
    assign div_ge = (div_t >= {1'b0, ramp_n});

    // ************************************************
    // next state
    // ************************************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.rd_valid = 1'b0;
        st_nxt.cmd_hit = 1'b0;
        st_nxt.inval = 1'b0;
        if (!st_r.loaded) begin
            st_nxt.loaded = 1'b1;
            st_nxt.wait_half = nvm_wait_mantissa[7:0];
            st_nxt.ramp_q = nvm_ramp_mantissa[6:0];
        end
        if (cmd_valid) begin
            st_nxt.rd_valid = !cmd_write;
            st_nxt.rd_data = 16'h0000;
            case (cmd_code)
                CMD_WAIT: begin
                    st_nxt.cmd_hit = 1'b1;
                    if (cmd_write && wait_if.ok) begin
                        st_nxt.wait_half = wait_if.quarters[8:1];
                    end else if (cmd_write) begin
                        st_nxt.inval = 1'b1;
                    end else begin
                        st_nxt.rd_data = {WAIT_EXP_RST, 3'h0, st_r.wait_half};
                    end
                end
                CMD_RAMP: begin
                    st_nxt.cmd_hit = 1'b1;
                    if (cmd_write && ramp_if.ok) begin
                        st_nxt.ramp_q = ramp_if.quarters[6:0];
                    end else if (cmd_write) begin
                        st_nxt.inval = 1'b1;
                    end else begin
                        st_nxt.rd_data = {RAMP_EXP_RST, 4'h0, st_r.ramp_q};
                    end
                end
                CMD_STATUS_BYTE: begin
                    st_nxt.cmd_hit = 1'b1;
                    if (cmd_write && cmd_wdata[7:0] == SB_CLEAR_BUSY) begin
                        st_nxt.busy = 1'b0;
                    end
                    st_nxt.rd_data = {8'h00, st_r.sb};
                end
                CMD_STATUS_WORD: begin
                    st_nxt.cmd_hit = cmd_write;
                    st_nxt.rd_valid = 1'b0;
                    if (cmd_write && (cmd_wdata == SW_CLEAR_BUSY || cmd_wdata == SW_CLEAR_BOTH)) begin
                        st_nxt.busy = 1'b0;
                    end
                    if (cmd_write && cmd_wdata == SW_CLEAR_BOTH) begin
                        st_nxt.unknown = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        // sets win over clears
        if (busy_event) begin
            st_nxt.busy = 1'b1;
        end
        if (turn_on_timeout) begin
            st_nxt.unknown = 1'b1;
        end
        if (alert_clear) begin
            st_nxt.alert = 1'b0;
        end
        if ((st_nxt.inval || turn_on_timeout) && !alert_mask) begin
            st_nxt.alert = 1'b1;
        end

        // shutdown sequencer
        unique case (st_r.seq)
            SEQ_OFF: begin
                st_nxt.ref_lvl = 12'h000;
                if (run_req) begin
                    st_nxt.seq = SEQ_RUN;
                end
            end
            SEQ_RUN: begin
                if (!run_req) begin
                    st_nxt.seq = SEQ_DIV;
                    st_nxt.quo = 13'(st_r.ref_lvl) + 13'(ramp_n) - 13'h0001;
                    st_nxt.rem = 8'h00;
                    st_nxt.dcnt = 4'h0;
                end else begin
                    st_nxt.ref_lvl = output_setpoint;
                end
            end
            SEQ_DIV: begin
                st_nxt.rem = div_ge ? (div_t - {1'b0, ramp_n}) : div_t;
                st_nxt.quo = {st_r.quo[11:0], div_ge};
                st_nxt.dcnt = st_r.dcnt + 4'h1;
                if (st_r.dcnt == 4'(DIV_STEPS - 1)) begin
                    st_nxt.seq = SEQ_WAIT;
                    st_nxt.tick = '0;
                    st_nxt.qcnt = 9'h000;
                end
            end
            SEQ_WAIT: begin
                if (st_r.qcnt == {st_r.wait_half, 1'b0}) begin
                    st_nxt.seq = SEQ_RAMP;
                    st_nxt.tick = '0;
                end else if (tick_end) begin
                    st_nxt.tick = '0;
                    st_nxt.qcnt = st_r.qcnt + 9'h001;
                end else begin
                    st_nxt.tick = st_r.tick + TICK_W'(1);
                end
            end
            SEQ_RAMP: begin
                if (st_r.ref_lvl == 12'h000) begin
                    st_nxt.seq = SEQ_OFF;
                end else if (tick_end) begin
                    st_nxt.tick = '0;
                    st_nxt.ref_lvl = (st_r.ref_lvl > st_r.quo[11:0]) ?
                        st_r.ref_lvl - st_r.quo[11:0] : 12'h000;
                end else begin
                    st_nxt.tick = st_r.tick + TICK_W'(1);
                end
            end
            default: begin
                st_nxt.seq = SEQ_OFF;
            end
        endcase

        st_nxt.sb = {st_nxt.busy,
            !(st_nxt.seq inside {SEQ_RUN, SEQ_DIV, SEQ_WAIT}),
            output_overvoltage_flag, output_overcurrent_flag, input_undervoltage_flag,
            temperature_flag, comm_memory_logic_flag,
            other_fault_flag | st_nxt.unknown};
    end

    // ************************************************
    // state register
    // ************************************************
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_r <= ST_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rd_data = st_r.rd_data;
    assign rd_valid = st_r.rd_valid;
    assign cmd_hit = st_r.cmd_hit;
    assign invalid_data = st_r.inval;
    assign energy_on = st_r.seq inside {SEQ_RUN, SEQ_DIV, SEQ_WAIT};
    assign ref_level = st_r.ref_lvl;
    assign fault_summary_byte = st_r.sb;
    assign alert_o = 1'b0;
    assign alert_oe = st_r.alert;

    // ************************************************
    // assertions
    // ************************************************
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    wait_read_a: assert property (cmd_valid && !cmd_write && cmd_code == CMD_WAIT
        |=> rd_valid && rd_data == {WAIT_EXP_RST, 3'h0, $past(st_r.wait_half)})
        else $error("wait time read back wrong");
    wait_reject_a: assert property (cmd_valid && cmd_write && cmd_code == CMD_WAIT
        && !wait_if.ok |=> invalid_data && $stable(st_r.wait_half))
        else $error("bad wait value not rejected");
    ramp_reject_a: assert property (cmd_valid && cmd_write && cmd_code == CMD_RAMP
        && !ramp_if.ok |=> invalid_data && $stable(st_r.ramp_q))
        else $error("bad ramp value not rejected");
    ramp_read_a: assert property (cmd_valid && !cmd_write && cmd_code == CMD_RAMP
        |=> rd_data[EXP_MSB:EXP_LSB] == RAMP_EXP_RST)
        else $error("ramp exponent not minus two");
    stop_latency_a: assert property (st_r.seq == SEQ_RUN && !run_req
        |=> (energy_on && st_r.dcnt == 4'h0) ##12 (energy_on && st_r.dcnt == 4'(DIV_STEPS - 1))
        ##1 (energy_on && st_r.seq == SEQ_WAIT))
        else $error("wait did not start within latency");
    energy_stop_a: assert property (st_r.seq == SEQ_WAIT && st_nxt.seq == SEQ_RAMP
        |=> !energy_on && fault_summary_byte[SB_OFF])
        else $error("energy not stopped after wait");
    ramp_step_a: assert property (st_r.seq == SEQ_RAMP && tick_end && ref_level != 12'h000
        |=> ref_level < $past(ref_level))
        else $error("reference not falling");
    busy_set_a: assert property (busy_event |=> fault_summary_byte[SB_BUSY])
        else $error("busy bit not set");
    busy_clear_a: assert property (cmd_valid && cmd_write && cmd_code == CMD_STATUS_BYTE
        && cmd_wdata[7:0] == SB_CLEAR_BUSY && !busy_event |=> !fault_summary_byte[SB_BUSY])
        else $error("busy bit not cleared");
    off_live_a: assert property (st_r.loaded |-> fault_summary_byte[SB_OFF] == !energy_on)
        else $error("off bit not live");
    word_clear_a: assert property (cmd_valid && cmd_write && cmd_code == CMD_STATUS_WORD
        && cmd_wdata == SW_CLEAR_BOTH && !turn_on_timeout && !other_fault_flag
        |=> !fault_summary_byte[SB_OTHER])
        else $error("unknown bit not cleared");
    timeout_flag_a: assert property (turn_on_timeout && !alert_mask
        |=> fault_summary_byte[SB_OTHER] && alert_oe)
        else $error("timeout not reported");

    stop_seq_c: cover property (st_r.seq == SEQ_RAMP ##1 st_r.seq == SEQ_OFF);
    invalid_c: cover property (invalid_data && alert_oe);
    busy_clear_c: cover property (fault_summary_byte[SB_BUSY] ##1 !fault_summary_byte[SB_BUSY]);

endmodule
`default_nettype wire

// file: bench/pmsob_host_model.sv
// host controller model that issues command-port transfers
`timescale 1ns/1ps
`default_nettype none
module pmsob_host_model
    import pmsob_pkg::*;
(
    input wire logic core_clk,
    output logic cmd_valid,
    output logic cmd_write,
    output logic [7:0] cmd_code,
    output logic [15:0] cmd_wdata,
    input wire logic [15:0] rd_data,
    input wire logic rd_valid,
    input wire logic cmd_hit,
    input wire logic invalid_data
);
    logic rvalid_seen;

    initial begin
        rvalid_seen = 1'h0;
        cmd_valid = 1'h0;
        cmd_write = 1'h0;
        cmd_code = 8'h00;
        cmd_wdata = 16'h0000;
    end

    // ************************************************
    // one command: strobe for one cycle, collect the answer
    // ************************************************
    task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] data,
                        output logic [15:0] rdata, output logic hit, output logic inval);
        @(negedge core_clk);
        cmd_valid = 1'h1;
        cmd_write = wr;
        cmd_code = code;
        cmd_wdata = (code == CMD_STATUS_BYTE) ? {~data[15:8], data[7:0]} : data;
        @(negedge core_clk);
        cmd_valid = 1'h0;
        cmd_write = ~wr;
        cmd_code = ~code;
        cmd_wdata = ~data;
        hit = cmd_hit;
        rvalid_seen = rd_valid;
        inval = invalid_data;
        @(negedge core_clk);
        hit = hit | cmd_hit;
        inval = inval | invalid_data;
        rdata = rd_data;
    endtask
endmodule
`default_nettype wire

// file: bench/pmsob_top_tb.sv
// self-checking bench for the soft-off and status-byte block
`timescale 1ns/1ps
`default_nettype none
module pmsob_top_tb
    import pmsob_pkg::*;
;
    localparam int QC = 4;
    typedef struct packed {
        logic wr;
        logic [7:0] code;
        logic [15:0] data;
        logic hit;
        logic inv;
        logic [15:0] rd;
    } pmsob_row_s;
    localparam pmsob_row_s ROWS [16] = '{
        '{1'h1, CMD_WAIT, 16'hf814, 1'h1, 1'h0, 16'h0000},
        '{1'h0, CMD_WAIT, 16'h0000, 1'h1, 1'h0, 16'hf814},
        '{1'h1, CMD_WAIT, 16'hf900, 1'h1, 1'h1, 16'h0000},
        '{1'h0, CMD_WAIT, 16'h0000, 1'h1, 1'h0, 16'hf814},
        '{1'h1, CMD_WAIT, 16'h0001, 1'h1, 1'h0, 16'h0000},
        '{1'h0, CMD_WAIT, 16'h0000, 1'h1, 1'h0, 16'hf802},
        '{1'h1, CMD_WAIT, 16'hf8ff, 1'h1, 1'h0, 16'h0000},
        '{1'h1, CMD_WAIT, 16'hf001, 1'h1, 1'h1, 16'h0000},
        '{1'h0, CMD_WAIT, 16'h0000, 1'h1, 1'h0, 16'hf8ff},
        '{1'h1, CMD_RAMP, 16'hf07f, 1'h1, 1'h0, 16'h0000},
        '{1'h1, CMD_RAMP, 16'hf080, 1'h1, 1'h1, 16'h0000},
        '{1'h1, CMD_RAMP, 16'hf7ff, 1'h1, 1'h1, 16'h0000},
        '{1'h0, CMD_RAMP, 16'h0000, 1'h1, 1'h0, 16'hf07f},
        '{1'h1, CMD_RAMP, 16'hf001, 1'h1, 1'h0, 16'h0000},
        '{1'h0, CMD_RAMP, 16'h0000, 1'h1, 1'h0, 16'hf001},
        '{1'h0, 8'h20, 16'h0000, 1'h0, 1'h0, 16'h0000}
    };
    logic core_clk = 1'h0;
    logic rst_n = 1'h0;
    logic cmd_valid, cmd_write, rd_valid, cmd_hit, invalid_data, energy_on, alert_o, alert_oe;
    logic [7:0] cmd_code, fault_summary_byte;
    logic [15:0] cmd_wdata, rd_data, d;
    logic run_req = 1'h0;
    logic [11:0] output_setpoint = 12'h000;
    logic [11:0] ref_level;
    logic [5:0] flg = 6'h00;
    logic turn_on_timeout = 1'h0;
    logic busy_event = 1'h0;
    logic alert_mask = 1'h0;
    logic alert_clear = 1'h0;
    logic h, v;
    int n_errors = 0;
    int compares = 0;

    always #10 core_clk = ~core_clk;

    pmsob_host_model host (.core_clk(core_clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rd_data(rd_data), .rd_valid(rd_valid),
        .cmd_hit(cmd_hit), .invalid_data(invalid_data));

    pmsob_top #(.QMS_CYCLES_P(QC)) dut (.core_clk(core_clk), .rst_n(rst_n),
        .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
        .cmd_wdata(cmd_wdata), .rd_data(rd_data), .rd_valid(rd_valid), .cmd_hit(cmd_hit),
        .invalid_data(invalid_data), .nvm_wait_mantissa(11'h006),
        .nvm_ramp_mantissa(11'h008), .run_req(run_req), .output_setpoint(output_setpoint),
        .output_overvoltage_flag(flg[5]), .output_overcurrent_flag(flg[4]),
        .input_undervoltage_flag(flg[3]), .temperature_flag(flg[2]),
        .comm_memory_logic_flag(flg[1]), .other_fault_flag(flg[0]),
        .turn_on_timeout(turn_on_timeout), .busy_event(busy_event), .alert_mask(alert_mask),
        .alert_clear(alert_clear), .energy_on(energy_on), .ref_level(ref_level),
        .fault_summary_byte(fault_summary_byte), .alert_o(alert_o), .alert_oe(alert_oe));

    // ************************************************
    // shared tasks
    // ************************************************
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic pulse(ref logic s);
        @(negedge core_clk);
        s = 1'h1;
        @(negedge core_clk);
        s = 1'h0;
        repeat (2) @(negedge core_clk);
    endtask

    task automatic sb(input logic [7:0] exp, input string nm);
        chk(nm, {8'h00, exp}, {8'h00, fault_summary_byte});
    endtask

    task automatic run_stop(input logic [15:0] ww, input logic [15:0] rw,
                            input logic [11:0] sp, input int wq, input int rq);
        int n1;
        int n2;
        n1 = 0;
        n2 = 0;
        host.xfer(1'h1, CMD_WAIT, ww, d, h, v);
        host.xfer(1'h1, CMD_RAMP, rw, d, h, v);
        output_setpoint = sp;
        run_req = 1'h1;
        repeat (400) @(negedge core_clk);
        chk("energy while running", 16'h0001, {15'h0, energy_on});
        sb(8'h00, "summary while running");
        run_req = 1'h0;
        while (energy_on === 1'h1 && n1 < 5000) begin
            @(negedge core_clk);
            n1++;
        end
        chk("wait span", 16'h0001,
            {15'h0, n1 >= 2 * wq * QC && n1 <= 2 * wq * QC + LATENCY_MAX_CYCLES});
        while (ref_level !== 12'h000 && n2 < 5000) begin
            @(negedge core_clk);
            n2++;
        end
        chk("ramp span", 16'h0001, {15'h0, n2 >= rq * QC - 2 && n2 <= rq * QC + QC + 2});
        repeat (2) @(negedge core_clk);
        sb(8'h40, "summary after stop");
        $display("test stop sequence done, wait %0d ramp %0d cycles", n1, n2);
    endtask

    // ************************************************
    // watchdog
    // ************************************************
    initial begin
        repeat (60000) @(posedge core_clk);
        n_errors++;
        $display("ERROR watchdog expected finish seen hang");
        give_verdict();
    end

    // ************************************************
    // main sequence
    // ************************************************
    initial begin
        repeat (16) @(negedge core_clk);
        sb(8'h00, "summary in reset");
        chk("alert in reset", 16'h0000, {15'h0, alert_oe});
        rst_n = 1'h1;
        repeat (3) @(negedge core_clk);
        sb(8'h40, "summary after reset");
        host.xfer(1'h0, CMD_WAIT, 16'h0000, d, h, v);
        chk("wait reset value", 16'hf806, d);
        host.xfer(1'h0, CMD_RAMP, 16'h0000, d, h, v);
        chk("ramp reset value", 16'hf008, d);
        $display("test reset done");
        foreach (ROWS[i]) begin
            host.xfer(ROWS[i].wr, ROWS[i].code, ROWS[i].data, d, h, v);
            chk("hit", {15'h0, ROWS[i].hit}, {15'h0, h});
            chk("read valid", {15'h0, !ROWS[i].wr}, {15'h0, host.rvalid_seen});
            chk("invalid", {15'h0, ROWS[i].inv}, {15'h0, v});
            if (!ROWS[i].wr) begin
                chk("read data", ROWS[i].rd, d);
            end
        end
        $display("test command rows done");
        chk("alert raised", 16'h0001, {15'h0, alert_oe});
        chk("alert data", 16'h0000, {15'h0, alert_o});
        pulse(alert_clear);
        chk("alert cleared", 16'h0000, {15'h0, alert_oe});
        alert_mask = 1'h1;
        host.xfer(1'h1, CMD_WAIT, 16'hf900, d, h, v);
        chk("alert masked", 16'h0000, {15'h0, alert_oe});
        alert_mask = 1'h0;
        $display("test alert done");
        for (int b = 0; b < 6; b++) begin
            flg = 6'h01 << b;
            repeat (2) @(negedge core_clk);
            sb(8'h40 | (8'h01 << b), "summary mirror");
        end
        flg = 6'h00;
        repeat (2) @(negedge core_clk);
        sb(8'h40, "summary mirror cleared");
        $display("test mirror done");
        pulse(busy_event);
        sb(8'hc0, "busy set");
        host.xfer(1'h1, CMD_STATUS_BYTE, 16'h0040, d, h, v);
        sb(8'hc0, "busy kept");
        host.xfer(1'h0, CMD_STATUS_BYTE, 16'h0000, d, h, v);
        chk("byte read", 16'h00c0, d);
        host.xfer(1'h1, CMD_STATUS_BYTE, 16'h0080, d, h, v);
        sb(8'h40, "busy cleared");
        pulse(turn_on_timeout);
        pulse(busy_event);
        sb(8'hc1, "timeout bit");
        host.xfer(1'h1, CMD_STATUS_WORD, 16'h0080, d, h, v);
        sb(8'h41, "word clear busy");
        pulse(busy_event);
        host.xfer(1'h1, CMD_STATUS_WORD, 16'h0180, d, h, v);
        sb(8'h40, "word clear both");
        $display("test busy and unknown done");
        run_stop(16'hf802, 16'hf004, 12'h100, 2, 4);
        run_stop(16'hf800, 16'hf004, 12'hfff, 0, 4);
        run_stop(16'hf802, 16'hf001, 12'h100, 2, 2);
        give_verdict();
    end
endmodule
`default_nettype wire
